//--- rtl/adcsq_top.sv
// Step configuration registers and APB slave for two four-step sample sequencers.
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
`default_nettype none
module adcsq_top
    import adcsq_pkg::*;
#(
    parameter int SEL_W = SEL_W_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire logic [1:0] seq_trig,
    output logic seq1_conv_req,
    output logic [SEL_W-1:0] seq1_conv_sel,
    output logic seq1_conv_temp,
    output logic seq1_conv_diff,
    input wire logic seq1_conv_done,
    output logic seq2_conv_req,
    output logic [SEL_W-1:0] seq2_conv_sel,
    output logic seq2_conv_temp,
    output logic seq2_conv_diff,
    input wire logic seq2_conv_done
);

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [15:0] seq1_input_select, next_seq1_input_select;
    logic [15:0] seq2_input_select, next_seq2_input_select;
    logic [15:0] seq1_step_control, next_seq1_step_control;
    logic [15:0] seq2_step_control, next_seq2_step_control;
    logic [1:0] trig_en, next_trig_en;
    logic [1:0] run_pulse, next_run_pulse;
    logic [31:0] next_prdata;
    logic next_pready;
    logic next_pslverr;
    logic setup;
    logic wr_en;
    logic hit;
    logic [31:0] rd_word;
    logic [IRQ_W-1:0] irq_status;
    logic [IRQ_W-1:0] irq_mask;
    logic [IRQ_W-1:0] irq_events;
    logic irq_clr_we;
    logic irq_mask_we;

    adcsq_step_if #(.SEL_W(SEL_W)) sq1 ();
    adcsq_step_if #(.SEL_W(SEL_W)) sq2 ();

    // Keeps only the legal select bits of each step group; the rest read zero.
    function automatic logic [15:0] sel_keep(input logic [15:0] word);
        logic [15:0] m;
        m = '0;
        for (int i = 0; i < STEPS; i++) begin
            for (int b = 0; b < SEL_W; b++) begin
                m[i * FIELD_W + b] = 1'b1;
            end
        end
        sel_keep = word & m;
    endfunction : sel_keep

    // Zero-extends a 16-bit configuration word onto the bus.
    function automatic logic [31:0] word16(input logic [15:0] v);
        word16 = {16'h0000, v};
    endfunction : word16

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    // Writes commit only at the edge that completes the access phase.
    assign setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite && !pslverr;

    always_comb begin
        rd_word = WORD_ZERO;
        hit = 1'b1;
        if (paddr == OFF_SEQ1_SEL) begin
            rd_word = word16(seq1_input_select);
        end else if (paddr == OFF_SEQ1_CTL) begin
            rd_word = word16(seq1_step_control);
        end else if (paddr == OFF_SEQ2_SEL) begin
            rd_word = word16(seq2_input_select);
        end else if (paddr == OFF_SEQ2_CTL) begin
            rd_word = word16(seq2_step_control);
        end else if (paddr == OFF_RUN) begin
            rd_word = {30'h0000_0000, sq2.busy, sq1.busy};
        end else if (paddr == OFF_IRQ_STATUS) begin
            rd_word = {28'h000_0000, irq_status};
        end else if (paddr == OFF_IRQ_MASK) begin
            rd_word = {28'h000_0000, irq_mask};
        end else if (paddr == OFF_TRIG_EN) begin
            rd_word = {30'h0000_0000, trig_en};
        end else begin
            hit = 1'b0;
        end
    end

    always_comb begin
        next_pready = setup;
        next_prdata = prdata;
        next_pslverr = pslverr;
        if (setup) begin
            next_prdata = pwrite ? WORD_ZERO : rd_word;
            next_pslverr = !hit;
        end else if (!psel) begin
            next_pslverr = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------------
    always_comb begin
        next_seq1_input_select = seq1_input_select;
        next_seq2_input_select = seq2_input_select;
        next_seq1_step_control = seq1_step_control;
        next_seq2_step_control = seq2_step_control;
        next_trig_en = trig_en;
        next_run_pulse = 2'h0;
        if (wr_en) begin
            if (paddr == OFF_SEQ1_SEL) begin
                next_seq1_input_select = sel_keep(pwdata[15:0]);
            end else if (paddr == OFF_SEQ1_CTL) begin
                next_seq1_step_control = pwdata[15:0];
            end else if (paddr == OFF_SEQ2_SEL) begin
                next_seq2_input_select = sel_keep(pwdata[15:0]);
            end else if (paddr == OFF_SEQ2_CTL) begin
                next_seq2_step_control = pwdata[15:0];
            end else if (paddr == OFF_RUN) begin
                next_run_pulse = pwdata[1:0];
            end else if (paddr == OFF_TRIG_EN) begin
                next_trig_en = pwdata[1:0];
            end
        end
        // A trigger held high restarts the sequence as soon as it ends.
        next_run_pulse = next_run_pulse | (next_trig_en & seq_trig);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq1_input_select <= SEL_RESET;
            seq2_input_select <= SEL_RESET;
            seq1_step_control <= CTL_RESET;
            seq2_step_control <= CTL_RESET;
            trig_en <= TRIG_RESET;
            run_pulse <= TRIG_RESET;
            prdata <= WORD_ZERO;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else if (pce) begin
            seq1_input_select <= next_seq1_input_select;
            seq2_input_select <= next_seq2_input_select;
            seq1_step_control <= next_seq1_step_control;
            seq2_step_control <= next_seq2_step_control;
            trig_en <= next_trig_en;
            run_pulse <= next_run_pulse;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    // ------------------------------------------------------------------
    // Sequencer engines
    // ------------------------------------------------------------------
    // The engines read the live configuration, so rewriting it mid-sequence
    // changes the steps that have not yet started.
    assign sq1.sel_cfg = seq1_input_select;
    assign sq1.ctl_cfg = seq1_step_control;
    assign sq1.start = run_pulse[RUN_SEQ1];
    assign sq1.conv_done = seq1_conv_done;
    assign sq2.sel_cfg = seq2_input_select;
    assign sq2.ctl_cfg = seq2_step_control;
    assign sq2.start = run_pulse[RUN_SEQ2];
    assign sq2.conv_done = seq2_conv_done;

    adcsq_engine #(.SEL_W(SEL_W)) u_seq1 (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .sq(sq1.engine)
    );

    adcsq_engine #(.SEL_W(SEL_W)) u_seq2 (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .sq(sq2.engine)
    );

    assign seq1_conv_req = sq1.conv_req;
    assign seq1_conv_sel = sq1.conv_sel;
    assign seq1_conv_temp = sq1.conv_temp;
    assign seq1_conv_diff = sq1.conv_diff;
    assign seq2_conv_req = sq2.conv_req;
    assign seq2_conv_sel = sq2.conv_sel;
    assign seq2_conv_temp = sq2.conv_temp;
    assign seq2_conv_diff = sq2.conv_diff;

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_comb begin
        irq_events = IRQ_RESET;
        irq_events[IRQ_SEQ1_STEP] = sq1.step_irq;
        irq_events[IRQ_SEQ2_STEP] = sq2.step_irq;
        irq_events[IRQ_SEQ1_DONE] = sq1.seq_done;
        irq_events[IRQ_SEQ2_DONE] = sq2.seq_done;
    end

    assign irq_clr_we = wr_en && (paddr == OFF_IRQ_STATUS);
    assign irq_mask_we = wr_en && (paddr == OFF_IRQ_MASK);

    adcsq_irq u_irq (
        .pclk(pclk),
        .presetn(presetn),
        .pce(pce),
        .events(irq_events),
        .clr_we(irq_clr_we),
        .mask_we(irq_mask_we),
        .wdata(pwdata[IRQ_W-1:0]),
        .status(irq_status),
        .mask(irq_mask),
        .irq(irq)
    );

endmodule : adcsq_top
`default_nettype wire

//--- rtl/adcsq_pkg.sv
// Package of register offsets, field layout and types for the two step sequencers.
package adcsq_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFF_RUN = 12'h000;
    localparam logic [11:0] OFF_IRQ_STATUS = 12'h004;
    localparam logic [11:0] OFF_IRQ_MASK = 12'h008;
    localparam logic [11:0] OFF_TRIG_EN = 12'h00C;
    localparam logic [11:0] OFF_SEQ1_SEL = 12'h060;
    localparam logic [11:0] OFF_SEQ1_CTL = 12'h064;
    localparam logic [11:0] OFF_SEQ2_SEL = 12'h080;
    localparam logic [11:0] OFF_SEQ2_CTL = 12'h084;

    // ------------------------------------------------------------------
    // Step layout
    // ------------------------------------------------------------------
    localparam int STEPS = 4;
    localparam int FIELD_W = 4;
    localparam int CFG_W = 16;
    localparam int SEL_W_DEF = 1;
    localparam int BIT_DIFF = 0;
    localparam int BIT_LAST = 1;
    localparam int BIT_IRQ_EN = 2;
    localparam int BIT_TEMP = 3;
    localparam logic [15:0] SEL_RESET = 16'h0000;
    localparam logic [15:0] CTL_RESET = 16'h0000;
    localparam logic [1:0] STEP_FIRST = 2'h0;
    localparam logic [1:0] STEP_FINAL = 2'h3;
    localparam logic [1:0] STEP_INC = 2'h1;

    // ------------------------------------------------------------------
    // Interrupt and control bits
    // ------------------------------------------------------------------
    localparam int IRQ_W = 4;
    localparam int IRQ_SEQ1_STEP = 0;
    localparam int IRQ_SEQ2_STEP = 1;
    localparam int IRQ_SEQ1_DONE = 2;
    localparam int IRQ_SEQ2_DONE = 3;
    localparam logic [3:0] IRQ_RESET = 4'h0;
    localparam int RUN_SEQ1 = 0;
    localparam int RUN_SEQ2 = 1;
    localparam logic [1:0] TRIG_RESET = 2'h0;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

    typedef enum logic {ADCSQ_IDLE, ADCSQ_CONV} adcsq_state_t;

    // Picks the four-bit group of one step out of a 16-bit configuration word.
    function automatic logic [3:0] adcsq_nibble(input logic [15:0] word, input logic [1:0] step);
        adcsq_nibble = word[step * FIELD_W +: FIELD_W];
    endfunction : adcsq_nibble

endpackage : adcsq_pkg

//--- rtl/adcsq_step_if.sv
// Interface between the register file and one step sequencer engine.
`timescale 1ns/100ps
`default_nettype none
interface adcsq_step_if #(
    parameter int SEL_W = 1
);
    logic [15:0] sel_cfg;
    logic [15:0] ctl_cfg;
    logic start;
    logic busy;
    logic conv_req;
    logic [SEL_W-1:0] conv_sel;
    logic conv_temp;
    logic conv_diff;
    logic conv_done;
    logic step_irq;
    logic seq_done;

    modport engine (
        input sel_cfg, ctl_cfg, start, conv_done,
        output busy, conv_req, conv_sel, conv_temp, conv_diff, step_irq, seq_done
    );
    modport regs (
        output sel_cfg, ctl_cfg, start, conv_done,
        input busy, conv_req, conv_sel, conv_temp, conv_diff, step_irq, seq_done
    );
endinterface : adcsq_step_if
`default_nettype wire

//--- rtl/adcsq_engine.sv
// Step sequencer engine: walks up to four steps and hands each to the converter.
`timescale 1ns/100ps
`default_nettype none
module adcsq_engine
    import adcsq_pkg::*;
#(
    parameter int SEL_W = SEL_W_DEF
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    adcsq_step_if.engine sq
);

    adcsq_state_t state, next_state;
    logic [1:0] step, next_step;
    logic conv_req, next_conv_req;
    logic [SEL_W-1:0] conv_sel, next_conv_sel;
    logic conv_temp, next_conv_temp;
    logic conv_diff, next_conv_diff;
    logic step_irq, next_step_irq;
    logic seq_done, next_seq_done;
    logic [3:0] ctl_now;
    logic [3:0] ctl_nxt;
    logic [3:0] ctl_first;
    logic [1:0] step_after;

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        ctl_now = adcsq_nibble(sq.ctl_cfg, step);
        step_after = step + STEP_INC;
        ctl_nxt = adcsq_nibble(sq.ctl_cfg, step_after);
        ctl_first = adcsq_nibble(sq.ctl_cfg, STEP_FIRST);
        next_state = state;
        next_step = step;
        next_conv_req = conv_req;
        next_conv_sel = conv_sel;
        next_conv_temp = conv_temp;
        next_conv_diff = conv_diff;
        next_step_irq = 1'b0;
        next_seq_done = 1'b0;
        case (state)
            ADCSQ_IDLE: begin
                if (sq.start) begin
                    // Always begins from step one.
                    next_state = ADCSQ_CONV;
                    next_step = STEP_FIRST;
                    next_conv_req = 1'b1;
                    next_conv_sel = SEL_W'(adcsq_nibble(sq.sel_cfg, STEP_FIRST));
                    next_conv_temp = ctl_first[BIT_TEMP];
                    next_conv_diff = ctl_first[BIT_DIFF];
                end
            end
            ADCSQ_CONV: begin
                if (sq.conv_done) begin
                    next_step_irq = ctl_now[BIT_IRQ_EN];
                    // Without any end flag the sequence still stops after step four.
                    if (ctl_now[BIT_LAST] || step == STEP_FINAL) begin
                        next_state = ADCSQ_IDLE;
                        next_conv_req = 1'b0;
                        next_seq_done = 1'b1;
                    end else begin
                        next_step = step_after;
                        next_conv_sel = SEL_W'(adcsq_nibble(sq.sel_cfg, step_after));
                        next_conv_temp = ctl_nxt[BIT_TEMP];
                        next_conv_diff = ctl_nxt[BIT_DIFF];
                    end
                end
            end
            default: begin
                next_state = ADCSQ_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------------
    // State registers
    // ------------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= ADCSQ_IDLE;
            step <= STEP_FIRST;
            conv_req <= 1'b0;
            conv_sel <= '0;
            conv_temp <= 1'b0;
            conv_diff <= 1'b0;
            step_irq <= 1'b0;
            seq_done <= 1'b0;
        end else if (pce) begin
            state <= next_state;
            step <= next_step;
            conv_req <= next_conv_req;
            conv_sel <= next_conv_sel;
            conv_temp <= next_conv_temp;
            conv_diff <= next_conv_diff;
            step_irq <= next_step_irq;
            seq_done <= next_seq_done;
        end
    end

    assign sq.busy = (state == ADCSQ_CONV);
    assign sq.conv_req = conv_req;
    assign sq.conv_sel = conv_sel;
    assign sq.conv_temp = conv_temp;
    assign sq.conv_diff = conv_diff;
    assign sq.step_irq = step_irq;
    assign sq.seq_done = seq_done;

endmodule : adcsq_engine
`default_nettype wire

//--- rtl/adcsq_irq.sv
// Sticky interrupt status with write-one-to-clear, mask and one level output.
`timescale 1ns/100ps
`default_nettype none
module adcsq_irq
    import adcsq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic [IRQ_W-1:0] events,
    input wire logic clr_we,
    input wire logic mask_we,
    input wire logic [IRQ_W-1:0] wdata,
    output logic [IRQ_W-1:0] status,
    output logic [IRQ_W-1:0] mask,
    output logic irq
);

    logic [IRQ_W-1:0] next_status;
    logic [IRQ_W-1:0] next_mask;
    logic next_irq;

    always_comb begin
        next_status = status;
        next_mask = mask;
        if (clr_we) begin
            next_status = status & ~wdata;
        end
        // A new event beats a clear in the same cycle.
        next_status = next_status | events;
        if (mask_we) begin
            next_mask = wdata;
        end
        next_irq = |(next_status & next_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= IRQ_RESET;
            mask <= IRQ_RESET;
            irq <= 1'b0;
        end else if (pce) begin
            status <= next_status;
            mask <= next_mask;
            irq <= next_irq;
        end
    end

endmodule : adcsq_irq
`default_nettype wire

//--- tb/adcsq_chk.sv
// Concurrent checks on the APB slave and the two step engines of the sequencer top.
`timescale 1ns/100ps
`default_nettype none
module adcsq_chk
    import adcsq_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic pce,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic irq,
    input wire logic seq1_conv_req,
    input wire logic seq1_conv_done,
    input wire logic seq2_conv_req,
    input wire logic seq2_conv_done
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic mapped;
    logic commit;
    logic cause;
    assign mapped = paddr inside {OFF_RUN, OFF_IRQ_STATUS, OFF_IRQ_MASK, OFF_TRIG_EN,
        OFF_SEQ1_SEL, OFF_SEQ1_CTL, OFF_SEQ2_SEL, OFF_SEQ2_CTL};
    assign commit = psel && penable && pready && pwrite;
    // Interrupt status only moves on a converter completion or a register write.
    assign cause = seq1_conv_done || seq2_conv_done || commit;

    chk_apb_answer: assert property (psel && !penable && pce |=> pready)
        else $error("pready missing after setup.");
    chk_ready_pulse: assert property (pready && pce |=> !pready)
        else $error("pready stood longer than one cycle.");
    chk_upper_zero: assert property (pready && !pwrite |-> prdata[31:16] == 16'h0000)
        else $error("Upper half of read data not zero.");
    chk_sel_layout: assert property (pready && !pwrite && !pslverr &&
        (paddr == OFF_SEQ1_SEL || paddr == OFF_SEQ2_SEL) |-> (prdata[15:0] & 16'hEEEE) == 16'h0000)
        else $error("Select register reads a bit outside the step slots.");
    chk_map_ok: assert property (pready && mapped |-> !pslverr)
        else $error("Error on a mapped register.");
    chk_unmapped_err: assert property (pready && !mapped |-> pslverr && (pwrite || prdata == 0))
        else $error("Unmapped access not refused.");
    chk_run_start: assert property (commit && paddr == OFF_RUN && pwdata[RUN_SEQ1] &&
        !seq1_conv_req |=> ##1 seq1_conv_req)
        else $error("Sequence one did not start two edges after run.");
    chk_req_hold: assert property (seq1_conv_req && !seq1_conv_done |=> seq1_conv_req)
        else $error("Sequence one stopped without a completion.");
    chk_req_end: assert property ($fell(seq2_conv_req) |-> $past(seq2_conv_done))
        else $error("Sequence two ended without a completion.");
    chk_irq_cause: assert property ($rose(irq) |-> $past(cause) || $past(cause, 2))
        else $error("Interrupt rose without a cause.");
endmodule : adcsq_chk

bind adcsq_top adcsq_chk i_chk (.pclk(pclk), .presetn(presetn), .pce(pce), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .seq1_conv_req(seq1_conv_req),
    .seq1_conv_done(seq1_conv_done), .seq2_conv_req(seq2_conv_req),
    .seq2_conv_done(seq2_conv_done));
`default_nettype wire

//--- tb/adcsq_tb_top.sv
// Self-checking bench for the two-sequencer step configuration block.
`timescale 1ns/100ps
`default_nettype none
module adcsq_tb_top
    import adcsq_pkg::*;
;
    localparam logic [11:0] REGS [4] = '{OFF_SEQ1_SEL, OFF_SEQ1_CTL, OFF_SEQ2_SEL, OFF_SEQ2_CTL};
    localparam logic [31:0] MASKS [4] = '{32'h1111, 32'hFFFF, 32'h1111, 32'hFFFF};
    localparam logic [31:0] PATS [4] = '{32'h0001, 32'h00A5, 32'h1000, 32'h5A00};
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic pce = 1'b1;
    logic [ADDR_W-1:0] paddr = '0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic irq;
    logic [1:0] seq_trig = 2'h0;
    logic [1:0] done_drv = 2'h0;
    wire logic [1:0] req;
    wire logic [1:0] sel;
    wire logic [1:0] temp;
    wire logic [1:0] diff;
    int fail_count = 0;
    int n_compared = 0;

    adcsq_top i_dut (.pclk(pclk), .presetn(presetn), .pce(pce), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .seq_trig(seq_trig), .seq1_conv_req(req[0]),
        .seq1_conv_sel(sel[0]), .seq1_conv_temp(temp[0]), .seq1_conv_diff(diff[0]),
        .seq1_conv_done(done_drv[0]), .seq2_conv_req(req[1]), .seq2_conv_sel(sel[1]),
        .seq2_conv_temp(temp[1]), .seq2_conv_diff(diff[1]), .seq2_conv_done(done_drv[1]));

    always #5 pclk = ~pclk;

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim

    // The request is held until pready is seen high; a bounded wait keeps a dead slave visible.
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        int i;
        logic ok;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        // Looking between edges avoids racing the slave's flops at the edge itself.
        do begin
            @(negedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 50);
        ok = (pready === 1'b1);
        r = prdata;
        e = pslverr;
        @(posedge pclk);
        psel <= 1'b0;
        penable <= 1'b0;
        if (!ok) check(32'h0, 32'h1);
    endtask : apb

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
        check({31'h0, e}, 32'h0);
    endtask : wr

    task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input logic experr);
        logic [31:0] r;
        logic e;
        apb(1'b0, a, 32'h0, r, e);
        check(r, exp);
        check({31'h0, e}, {31'h0, experr});
    endtask : rdc

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 4; i++) rdc(REGS[i], 32'h0, 1'b0);
    endtask : t_reset

    task automatic t_regs();
        logic [31:0] r;
        logic e;
        for (int i = 0; i < 4; i++) begin
            wr(REGS[i], 32'hFFFF_FFFF);
            rdc(REGS[i], MASKS[i], 1'b0);
        end
        for (int i = 0; i < 4; i++) wr(REGS[i], PATS[i]);
        apb(1'b1, 12'h068, 32'hFFFF_FFFF, r, e);
        check({31'h0, e}, 32'h1);
        rdc(12'h068, 32'h0, 1'b1);
        for (int i = 0; i < 4; i++) rdc(REGS[i], PATS[i], 1'b0);
    endtask : t_regs

    task automatic run_seq(input int s, input logic [15:0] sv, input logic [15:0] cv, input int n);
        int w;
        logic ie;
        ie = 1'b0;
        wr(s ? OFF_SEQ2_SEL : OFF_SEQ1_SEL, {16'h0, sv});
        wr(s ? OFF_SEQ2_CTL : OFF_SEQ1_CTL, {16'h0, cv});
        if (s == 1) begin
            wr(OFF_TRIG_EN, 32'h2);
            @(posedge pclk);
            seq_trig <= 2'h2;
            @(posedge pclk);
            seq_trig <= 2'h0;
        end else begin
            wr(OFF_RUN, 32'h1);
        end
        w = 0;
        do begin
            @(posedge pclk);
            #1;
            w++;
        end while (req[s] !== 1'b1 && w < 20);
        rdc(OFF_RUN, 32'h1 << s, 1'b0);
        for (int k = 0; k < n; k++) begin
            check({28'h0, req[s], sel[s], temp[s], diff[s]},
                {28'h0, 1'b1, sv[4*k], cv[4*k+3], cv[4*k]});
            ie = ie | cv[4*k+2];
            @(posedge pclk);
            done_drv[s] <= 1'b1;
            @(posedge pclk);
            done_drv[s] <= 1'b0;
            #1;
        end
        check({31'h0, req[s]}, 32'h0);
        rdc(OFF_IRQ_STATUS, ({31'h0, ie} | 32'h4) << s, 1'b0);
        check({31'h0, irq}, 32'h0);
        wr(OFF_IRQ_MASK, 32'hF);
        repeat (2) @(posedge pclk);
        #1;
        check({31'h0, irq}, 32'h1);
        wr(OFF_IRQ_STATUS, 32'hF);
        wr(OFF_IRQ_MASK, 32'h0);
        rdc(OFF_IRQ_STATUS, 32'h0, 1'b0);
        check({31'h0, irq}, 32'h0);
    endtask : run_seq

    // A reset in mid-sequence must drop the request and clear the four step configuration registers.
    task automatic t_midreset();
        logic [31:0] r;
        logic e;
        apb(1'b0, OFF_SEQ1_CTL, 32'h0, r, e);
        wr(OFF_SEQ1_CTL, (r & 32'hFFFF_0000) | 32'h0000_0002);
        wr(OFF_RUN, 32'h1);
        repeat (3) @(posedge pclk);
        // A completion that arrives while the clock enable is low must be lost.
        pce <= 1'b0;
        @(posedge pclk);
        done_drv[0] <= 1'b1;
        @(posedge pclk);
        done_drv[0] <= 1'b0;
        pce <= 1'b1;
        @(posedge pclk);
        #1;
        check({31'h0, req[0]}, 32'h1);
        presetn <= 1'b0;
        @(posedge pclk);
        #1;
        check({31'h0, req[0]}, 32'h0);
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
    endtask : t_midreset

    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_regs();
        run_seq(0, 16'h0101, 16'h0249, 3);
        run_seq(0, 16'h1011, 16'h0002, 1);
        run_seq(1, 16'h1001, 16'hBD54, 4);
        run_seq(1, 16'h0110, 16'h0D20, 2);
        t_midreset();
        end_sim();
    end

    initial begin
        #100000;
        fail_count++;
        end_sim();
    end
endmodule : adcsq_tb_top
`default_nettype wire
